// ---- design/bhr_bus_hold.sv ----
/*
  Bus-hold handshake and reset pin-state control of the external memory
  port. Assumes the core supplies its transaction status and its
  functional values for each pin group; this block decides when the
  memory and serial/host pins float and gates the reset pin groups.
*/
`timescale 1ns/1ns
// Functional notes
// - float bus no sooner than 4P after request
// - grant low 1P to 2P after float
// - grant high 4P to 7P after release
// - redrive bus 3P to 6P after release
// - finish pending transfers before granting bus
// - worst delay: ready-stretched or SDRAM burst
// - idle bus grants after minimum delay
// - inhibit bit withholds grant indefinitely
// - floated set: all memory port pins
// - reset never controls the clock PLL
// - reset change acted on after two cycles
// - low group driven low in reset
// - host interrupt driven high in reset
// - memory, host data, serial pins float
// - host ready level set by host select
// - bus request synchronised, async allowed
module bhr_bus_hold
  import bhr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clkEn,
  input  wire logic         resetPinN,
  input  wire logic         busRequestN,
  input  wire logic         grantInhibitBit,
  input  wire logic         sdramBurstArbBit,
  input  wire logic         asyncReadyIn,
  input  wire logic         memBusy,
  input  wire logic         hostSelectIn,
  input  wire bhr_low_grp_s lowGrpCore,
  input  wire logic         hostIrqCore,
  input  wire logic         hostReadyCore,
  input  wire logic         hostDataOeCore,
  input  wire logic         serialOeCore,
  output logic              busGrantOut,
  output logic              memBusOe,
  output logic              memStartAllow,
  output logic              hostDataOe,
  output logic              serialOe,
  output logic              deviceInReset,
  output bhr_low_grp_s      lowGrpOut,
  output logic              hostIrqOut,
  output logic              hostReadyOut
);

  bhr_state_s r, n;
  logic       holdReq;
  logic       idle;

  // Request seen low after the second synchroniser stage.
  assign holdReq = ~r.holdSync[1];
  // Busy covers ready-stretched async and chained SDRAM accesses; the
  // burst-arbitration bit only lengthens the run the core reports.
  assign idle = ~memBusy;

  always_comb begin
    n = r;
    n.holdSync = {r.holdSync[0], busRequestN};
    // Reset pin is acted on only after passing three flops.
    n.rstSync  = {r.rstSync[1:0], resetPinN};
    n.inReset  = ~r.rstSync[RST_SYNC_LEN];
    // The host select pin is asynchronous, so it is synchronised first.
    n.hostSelSync = {r.hostSelSync[0], hostSelectIn};
    if (r.count != 4'h0) begin
      n.count = r.count - 4'h1;
    end
    case (r.state)
      ST_OWN: begin
        // Inhibit keeps the handshake from starting; new transfers still stop.
        if (holdReq && !grantInhibitBit && !r.inReset) begin
          n.state = ST_DRAIN;
          n.count = FLOAT_CNT - 4'h1;
        end
      end
      ST_DRAIN: begin
        // Wait both for the minimum and for pending work.
        // Setting the inhibit bit mid-drain also abandons the hold.
        if (!holdReq || grantInhibitBit) begin
          n.state = ST_OWN;
        end else if (r.count == 4'h0 && idle) begin
          n.state    = ST_FLOAT;
          n.memDrive = 1'b0;
          n.count    = GRANT_CNT - 4'h1;
        end
      end
      ST_FLOAT: begin
        if (r.count == 4'h0) begin
          n.state  = ST_GRANT;
          n.grantN = 1'b0;
        end
      end
      ST_GRANT: begin
        if (!holdReq) begin
          n.state = ST_RECLAIM;
          n.count = DRIVE_CNT - 4'h2;
        end
      end
      ST_RECLAIM: begin
        if (r.count == 4'h0) begin
          n.state    = ST_UNGRANT;
          n.memDrive = 1'b1;
          n.count    = UNGRANT_CNT - DRIVE_CNT - 4'h1;
        end
      end
      ST_UNGRANT: begin
        if (r.count == 4'h0) begin
          n.state  = ST_OWN;
          n.grantN = 1'b1;
        end
      end
      default: begin
        n.state = ST_OWN;
      end
    endcase
    // Host select level captured while reset is held.
    if (r.inReset) begin
      n.hostSelLatched = r.hostSelSync[1];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{state: ST_OWN, count: 4'h0, holdSync: 2'h3, rstSync: 3'h7,
             inReset: 1'b0, memDrive: 1'b1, grantN: 1'b1,
             hostSelLatched: 1'b1, hostSelSync: 2'h3};
    end else if (clkEn) begin
      r <= n;
    end
  end

  // The PLL is outside this block; the reset pin touches only pins.
  assign deviceInReset = r.inReset;
  assign busGrantOut   = r.grantN;
  // The floated set is the whole memory port, one shared enable.
  assign memBusOe      = r.memDrive & ~r.inReset;
  assign hostDataOe    = hostDataOeCore & ~r.inReset;
  assign serialOe      = serialOeCore & ~r.inReset;
  // New transfers stop as soon as the synchronised request is seen.
  assign memStartAllow = (r.state == ST_OWN) && !holdReq && !r.inReset;
  assign lowGrpOut     = r.inReset ? '0 : lowGrpCore;
  assign hostIrqOut    = r.inReset ? 1'b1 : hostIrqCore;
  assign hostReadyOut  = r.inReset ? ~r.hostSelLatched
                                   : hostReadyCore;

  property p_float_min;
    @(posedge clk) disable iff (!resetn)
    $fell(memBusOe) && !r.inReset |-> $past(holdReq, 4);
  endproperty
  a_float_min: assert property (p_float_min)
    else $error("Bus floated too soon after request.");

  property p_grant_after_float;
    @(posedge clk) disable iff (!resetn)
    $fell(busGrantOut) |-> $past(!r.memDrive)
      && ($past(r.memDrive, 2) || $past(r.memDrive, 3));
  endproperty
  a_grant_after_float: assert property (p_grant_after_float)
    else $error("Grant not 1 to 2 cycles after float.");

  sequence s_release;
    $rose(r.holdSync[1]) && busGrantOut == 1'b0;
  endsequence
  property p_ungrant;
    @(posedge clk) disable iff (!resetn || !clkEn)
    s_release |-> !busGrantOut[*3] ##[1:3] busGrantOut;
  endproperty
  a_ungrant: assert property (p_ungrant)
    else $error("Grant release outside 4 to 7 cycles.");

  property p_redrive;
    @(posedge clk) disable iff (!resetn || !clkEn)
    s_release |-> !r.memDrive[*2] ##[1:4] r.memDrive;
  endproperty
  a_redrive: assert property (p_redrive)
    else $error("Bus redrive outside 3 to 6 cycles.");

  property p_no_grant_busy;
    @(posedge clk) disable iff (!resetn)
    (r.state == ST_DRAIN) && memBusy |=> r.memDrive;
  endproperty
  a_no_grant_busy: assert property (p_no_grant_busy)
    else $error("Bus floated with a transfer pending.");

  property p_inhibit;
    @(posedge clk) disable iff (!resetn)
    $fell(busGrantOut) |-> !$past(grantInhibitBit, 2);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("Grant given while inhibited.");

  property p_rst_resp;
    @(posedge clk) disable iff (!resetn || !clkEn)
    $rose(deviceInReset) |-> $past(!resetPinN, 2);
  endproperty
  a_rst_resp: assert property (p_rst_resp)
    else $error("Reset acted on sooner than two cycles.");

  property p_rst_pins;
    @(posedge clk) disable iff (!resetn)
    deviceInReset |-> lowGrpOut == '0 && hostIrqOut && !memBusOe
      && !hostDataOe && !serialOe;
  endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("Pin group wrong during reset.");

  property p_no_start;
    @(posedge clk) disable iff (!resetn)
    !busGrantOut |-> !memStartAllow;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("Transfer allowed while bus granted.");

endmodule

// ---- design/bhr_pkg.sv ----
/*
  Package for the bus-hold and reset pin sequencer: timing constants,
  state enumeration, the low-group carrier struct and the state register struct.
  Assumes one 100 MHz core clock, so one CPU clock period P is one cycle.
*/
package bhr_pkg;

  localparam int CLK_PERIOD_NS = 10;
  // Hold timing in CPU clock periods, as printed.
  localparam int HOLD_FLOAT_MIN_P  = 4;
  localparam int GRANT_DLY_MIN_P   = 1;
  localparam int GRANT_DLY_MAX_P   = 2;
  localparam int REL_GRANT_MIN_P   = 4;
  localparam int REL_GRANT_MAX_P   = 7;
  localparam int REL_DRIVE_MIN_P   = 3;
  localparam int REL_DRIVE_MAX_P   = 6;
  // Reset response, in output-clock cycles.
  localparam int RST_RESP_MIN_CYC  = 2;
  localparam int SDRAM_RUN_LEN     = 8;

  // Cycle counts; one P equals one clock here.
  localparam logic [3:0] FLOAT_CNT   = 4'(HOLD_FLOAT_MIN_P);
  localparam logic [3:0] GRANT_CNT   = 4'(GRANT_DLY_MIN_P);
  localparam logic [3:0] DRIVE_CNT   = 4'(REL_DRIVE_MIN_P);
  localparam logic [3:0] UNGRANT_CNT = 4'(REL_GRANT_MIN_P);
  localparam logic [1:0] RST_SYNC_LEN = 2'(RST_RESP_MIN_CYC);

  localparam logic [3:0]  DMA_EV_RST  = 4'h0;
  localparam logic [3:0]  INT_NUM_RST = 4'h0;

  typedef enum {
    ST_OWN,
    ST_DRAIN,
    ST_FLOAT,
    ST_GRANT,
    ST_RECLAIM,
    ST_UNGRANT
  } bhr_state_e;

  // Low-group outputs: forced low while reset is active.
  typedef struct packed {
    logic       intAck;
    logic [3:0] intNum;
    logic [3:0] dmaEvent;
    logic       powerdown;
    logic       timer0;
    logic       timer1;
  } bhr_low_grp_s;

  typedef struct packed {
    bhr_state_e state;
    logic [3:0] count;
    logic [1:0] holdSync;
    logic [2:0] rstSync;
    logic       inReset;
    logic       memDrive;
    logic       grantN;
    logic       hostSelLatched;
    logic [1:0] hostSelSync;
  } bhr_state_s;

endpackage

// ---- tb/bhr_bus_master.sv ----
/*
  Model of the external master that borrows the memory port.
  Assumes the bench raises want to ask for the bus and lowers it to
  hand the bus back; the model has no bus drivers of its own.
*/
`timescale 1ns/1ns
module bhr_bus_master (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic want,
  input  wire logic busGrantOut,
  output logic      busRequestN
);
  // A fresh request waits for the previous grant to clear, so the
  // port is never asked for again while it is still being handed back.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busRequestN <= 1'b1;
    end else begin
      busRequestN <= !(want && (!busRequestN || busGrantOut));
    end
  end
endmodule

// ---- tb/test_bhr_bus_hold.sv ----
/*
  Self-checking bench for the bus-hold and reset pin sequencer.
  Assumes a 100 MHz clock and the bus master model beside the design.
*/
`timescale 1ns/1ns
module test_bhr_bus_hold
  import bhr_pkg::*;
;
  logic clk = 0, resetn = 0, resetPinN = 1, busRequestN, want = 0;
  logic inhibit = 0, memBusy = 0, hostSel = 0;
  bhr_low_grp_s lowCore = '1, lowOut;
  logic grant, oe, startOk, hdOe, serOe, inRst, irq, rdy;
  int err_total = 0, tests_run = 0, cyc = 0;
  int tReq, tFloat, tGrant, tRel, tDrive, tUngr, tIdle;
  // A PLL start-up may need the reset pin low for 250 us.
  localparam int PLL_RST_CYC = 250000 / CLK_PERIOD_NS;

  always #5 clk = ~clk;

  bhr_bus_hold i_dut (.clk(clk), .resetn(resetn), .clkEn(1'b1),
    .resetPinN(resetPinN), .busRequestN(busRequestN),
    .grantInhibitBit(inhibit), .sdramBurstArbBit(1'b0),
    .asyncReadyIn(1'b1), .memBusy(memBusy), .hostSelectIn(hostSel),
    .lowGrpCore(lowCore), .hostIrqCore(hostSel),
    .hostReadyCore(hostSel), .hostDataOeCore(1'b1), .serialOeCore(1'b1),
    .busGrantOut(grant), .memBusOe(oe), .memStartAllow(startOk),
    .hostDataOe(hdOe), .serialOe(serOe), .deviceInReset(inRst),
    .lowGrpOut(lowOut), .hostIrqOut(irq), .hostReadyOut(rdy));

  bhr_bus_master i_master (.clk(clk), .resetn(resetn), .want(want),
    .busGrantOut(grant), .busRequestN(busRequestN));

  // Edge times are all taken by this one monitor, so their offsets cancel.
  always @(posedge clk) begin
    cyc++;
    if ($fell(busRequestN)) tReq = cyc;
    if ($rose(busRequestN)) tRel = cyc;
    if ($fell(oe)) tFloat = cyc;
    if ($rose(oe)) tDrive = cyc;
    if ($fell(grant)) tGrant = cyc;
    if ($rose(grant)) tUngr = cyc;
    if ($fell(memBusy)) tIdle = cyc;
    // The long reset dominates the run; the rest needs a few hundred.
    if (cyc > 30000) begin
      err_total++;
      test_done();
    end
  end

  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task chk(string n, logic [11:0] e, logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task rng(string n, int lo, int hi, int v);
    tests_run++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("mismatch %s expected %0d to %0d seen %0d", n, lo, hi, v);
    end
  endtask

  task waitG(logic v);
    for (int i = 0; i < 80 && grant !== v; i++) tick(1);
    chk("grant", 12'(v), 12'(grant));
  endtask

  task pin_reset(logic sel, int len);
    @(posedge clk) begin hostSel <= sel; resetPinN <= 0; end
    tick(2);
    chk("in reset", 0, 12'(inRst));
    tick(len - 2);
    chk("in reset", 1, 12'(inRst));
    chk("low group", 0, lowOut);
    chk("host irq", 1, 12'(irq));
    chk("host ready", 12'(!sel), 12'(rdy));
    chk("enables", 0, {oe, hdOe, serOe});
    @(posedge clk) resetPinN <= 1;
    tick(2);
    chk("in reset", 1, 12'(inRst));
    tick(2);
    chk("low group", lowCore, lowOut);
    chk("pins", 12'({sel, sel, 3'h7}), {irq,rdy,oe,hdOe,serOe});
  endtask

  // With busy nonzero, a pending transfer, held busy for busy+6 cycles, is in flight when the request comes.
  task hold(int busy);
    @(posedge clk) memBusy <= (busy > 0);
    @(posedge clk) want <= 1;
    tick(busy + 4);
    chk("bus oe", 1, 12'(oe));
    chk("start", 0, 12'(startOk));
    @(posedge clk) memBusy <= 0;
    waitG(0);
    tick(2);
    // The fall of oe is seen one edge after the edge that launches it.
    if (busy == 0) rng("float", 4, 6, tFloat - tReq - 1);
    else rng("float after busy", 1, 8, tFloat - tIdle);
    rng("grant", 1, 2, tGrant - tFloat);
    chk("start", 0, 12'(startOk));
    @(posedge clk) want <= 0;
    waitG(1);
    tick(2);
    rng("redrive", 3, 6, tDrive - tRel);
    rng("ungrant", 4, 7, tUngr - tRel);
    chk("start", 1, 12'(startOk));
  endtask

  task inhibit_hold();
    @(posedge clk) begin inhibit <= 1; want <= 1; end
    tick(40);
    chk("grant", 1, 12'(grant));
    chk("bus oe", 1, 12'(oe));
    @(posedge clk) want <= 0;
    tick(10);
    @(posedge clk) inhibit <= 0;
  endtask

  task test_done();
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    pin_reset(1'b0, PLL_RST_CYC);
    pin_reset(1'b0, 10);
    pin_reset(1'b1, 10);
    hold(0);
    hold(12);
    inhibit_hold();
    hold(0);
    test_done();
  end
endmodule
